// ===== hdl/scfm_top.sv
`include "scfm_map.svh"

module scfm_top (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TWO_SPEED_EN,
  input wire logic FAIL_MON_EN,
  input wire scfm_pkg::scfm_osc_mode_t OSC_MODE,
  input wire logic POWER_UP_TIMER_EN,
  input wire logic POWER_UP_TIMER_DONE,
  input wire logic WAKE_EVENT,
  input wire logic EXT_CLK,
  input wire logic LF_OSC,
  output logic PRI_CLK_EN,
  output logic INT_CLK_EN,
  output logic [2:0] INT_FREQ_SEL,
  output logic CPU_HOLD,
  output logic IRQ
);
  import scfm_pkg::*;

  localparam logic [5:0] SAMP_HALF_M1 = 6'(`SCFM_LF_DIV / 2 - 1);
  localparam logic [5:0] SAMP_FULL_M1 = 6'(`SCFM_LF_DIV - 1);
  localparam logic [10:0] OST_LAST = 11'(`SCFM_OST_CYCLES - 1);

  function automatic logic is_crystal(input scfm_osc_mode_t m);
    return (m == LOW_POWER_CRYSTAL) || (m == CRYSTAL_RESONATOR) || (m == HIGH_SPEED_CRYSTAL);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `SCFM_CTRL_OFS) || (a == `SCFM_FLAGS_OFS) ||
           (a == `SCFM_CLEAR_OFS) || (a == `SCFM_ENABLE_OFS);
  endfunction

  // pin synchronisers; the second stages and their delayed copies feed edge detection
  logic ext_s1, ext_s2, ext_d;
  logic lf_s1, lf_s2, lf_d;
  logic ext_fall, lf_rise;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_d <= 1'b0;
      lf_s1 <= 1'b0;
      lf_s2 <= 1'b0;
      lf_d <= 1'b0;
    end
    else
    begin
      ext_s1 <= EXT_CLK;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
      lf_s1 <= LF_OSC;
      lf_s2 <= lf_s1;
      lf_d <= lf_s2;
    end
  end

  assign ext_fall = ext_d & ~ext_s2;
  assign lf_rise = lf_s2 & ~lf_d;

  // state
  scfm_state_t state, next_state;
  logic [10:0] ost_cnt, next_ost_cnt;
  logic [5:0] lf_cnt, next_lf_cnt;
  logic fsd_latch, next_fsd_latch;
  logic armed, next_armed;
  logic pri_en, next_pri_en;
  logic int_en, next_int_en;
  logic [2:0] freq_sel, next_freq_sel;
  logic fail_flag, next_fail_flag;
  logic fail_ie, next_fail_ie;
  logic [31:0] prdata, next_prdata;

  logic samp_rise, samp_fall, mon, fail_ev, ost_done;
  logic wr, rd_setup, restart, want_pri, want_int;

  // sample clock: divided low-frequency oscillator
  assign samp_rise = lf_rise && (lf_cnt == SAMP_HALF_M1);
  assign samp_fall = lf_rise && (lf_cnt == SAMP_FULL_M1);

  // monitor runs only on the primary clock, which is after the timer
  assign mon = FAIL_MON_EN && (state == ST_PRIMARY);

  // a falling edge landing on the sample fall still counts as seen
  assign fail_ev = mon && armed && samp_fall && !fsd_latch && !ext_fall;

  assign ost_done = !is_crystal(OSC_MODE) || (ext_fall && (ost_cnt == OST_LAST));

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign restart = wr && (PADDR == `SCFM_CTRL_OFS) && PWDATA[`SCFM_RESTART_BIT] &&
                   ((state == ST_PRIMARY) || (state == ST_FAILED));

  always_comb
  begin
    next_lf_cnt = lf_rise ? 6'(lf_cnt + 6'h1) : lf_cnt;
    next_fsd_latch = fsd_latch;
    if (samp_rise)
      next_fsd_latch = 1'b0;
    if (ext_fall)
      next_fsd_latch = 1'b1;
    next_armed = armed;
    if (!mon)
      next_armed = 1'b0;
    else if (samp_rise)
      next_armed = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      lf_cnt <= 6'h00;
      fsd_latch <= 1'b0;
      armed <= 1'b0;
    end
    else
    begin
      lf_cnt <= next_lf_cnt;
      fsd_latch <= next_fsd_latch;
      armed <= next_armed;
    end
  end

  // start-up sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_POR:
        next_state = POWER_UP_TIMER_EN ? ST_POWER_UP : ST_OST;
      ST_POWER_UP:
        if (POWER_UP_TIMER_DONE)
          next_state = ST_OST;
      ST_OST:
        if (ost_done)
          next_state = ST_PRIMARY;
      ST_PRIMARY:
        if (fail_ev)
          next_state = ST_FAILED;
        else if (WAKE_EVENT)
          next_state = ST_OST;
      ST_FAILED:
        next_state = ST_FAILED;
    endcase
    if (restart && !fail_ev)
      next_state = ST_OST;
    if (WAKE_EVENT && (state == ST_OST))
      next_state = ST_OST;
    next_ost_cnt = ost_cnt;
    if (state != ST_OST || WAKE_EVENT)
      next_ost_cnt = 11'h000;
    else if (ext_fall)
      next_ost_cnt = 11'(ost_cnt + 11'h001);
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state <= ST_POR;
      ost_cnt <= 11'h000;
    end
    else
    begin
      state <= next_state;
      ost_cnt <= next_ost_cnt;
    end
  end

  // break-before-make clock select; both enables low for a cycle in between
  assign want_pri = (state == ST_PRIMARY);
  assign want_int = (state == ST_FAILED) || ((state == ST_OST) && TWO_SPEED_EN);

  always_comb
  begin
    next_pri_en = pri_en;
    next_int_en = int_en;
    if (!want_pri)
      next_pri_en = 1'b0;
    else if (!int_en)
      next_pri_en = 1'b1;
    if (!want_int)
      next_int_en = 1'b0;
    else if (!pri_en)
      next_int_en = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pri_en <= 1'b0;
      int_en <= 1'b0;
    end
    else
    begin
      pri_en <= next_pri_en;
      int_en <= next_int_en;
    end
  end

  assign PRI_CLK_EN = pri_en;
  assign INT_CLK_EN = int_en;
  // no clock granted means the core waits
  assign CPU_HOLD = !pri_en && !int_en;
  assign INT_FREQ_SEL = freq_sel;

  // register file
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == `SCFM_CTRL_OFS)
    begin
      w[`SCFM_FREQ_MSB:`SCFM_FREQ_LSB] = freq_sel;
      w[`SCFM_ACTIVE_BIT] = pri_en;
    end
    else if (a == `SCFM_FLAGS_OFS)
      w[`SCFM_FAIL_BIT] = fail_flag;
    else if (a == `SCFM_ENABLE_OFS)
      w[`SCFM_FAIL_BIT] = fail_ie;
    return w;
  endfunction

  always_comb
  begin
    next_freq_sel = freq_sel;
    if (wr && PADDR == `SCFM_CTRL_OFS)
      next_freq_sel = PWDATA[`SCFM_FREQ_MSB:`SCFM_FREQ_LSB];
    next_fail_ie = fail_ie;
    if (wr && PADDR == `SCFM_ENABLE_OFS)
      next_fail_ie = PWDATA[`SCFM_FAIL_BIT];
    next_fail_flag = fail_flag;
    if (wr && PADDR == `SCFM_CLEAR_OFS && PWDATA[`SCFM_FAIL_BIT])
      next_fail_flag = 1'b0;
    // set beats a clear in the same cycle
    if (fail_ev)
      next_fail_flag = 1'b1;
    next_prdata = rd_setup ? read_word(PADDR) : prdata;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      freq_sel <= `SCFM_FREQ_RESET;
      fail_flag <= 1'b0;
      fail_ie <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      freq_sel <= next_freq_sel;
      fail_flag <= next_fail_flag;
      fail_ie <= next_fail_ie;
      prdata <= next_prdata;
    end
  end

  // zero-wait slave; read data captured in the setup cycle
  assign PRDATA = prdata;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !is_mapped(PADDR);
  assign IRQ = fail_flag && fail_ie;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  hold_no_twospeed_a: assert property (
    (state == ST_OST && !TWO_SPEED_EN) [*2] |-> CPU_HOLD && !INT_CLK_EN)
    else $error("clock granted during timer without two-speed start-up");

  ost_count_a: assert property (
    (state == ST_OST && is_crystal(OSC_MODE) && !WAKE_EVENT) ##1 (state == ST_PRIMARY)
    |-> $past(ost_cnt) == OST_LAST)
    else $error("crystal start-up left timer before 1024 edges");

  two_speed_run_a: assert property (
    (state == ST_OST && TWO_SPEED_EN) [*4] |-> INT_CLK_EN && !CPU_HOLD)
    else $error("internal clock not running during two-speed start-up");

  switch_back_a: assert property (
    (state == ST_PRIMARY) [*3] |-> PRI_CLK_EN && !INT_CLK_EN)
    else $error("primary clock not selected after timer expiry");

  por_start_a: assert property (
    (state == ST_POR && !POWER_UP_TIMER_EN) |=> state == ST_OST)
    else $error("power-on did not start the timer");

  active_read_a: assert property (
    (PSEL && !PENABLE && !PWRITE && PADDR == `SCFM_CTRL_OFS)
    |=> PRDATA[`SCFM_ACTIVE_BIT] == $past(pri_en))
    else $error("primary_clock_active read mismatch");

  fail_window_a: assert property (
    fail_ev |-> $past(state == ST_PRIMARY) && FAIL_MON_EN)
    else $error("failure reported outside monitoring");

  latch_set_a: assert property (
    ext_fall |=> fsd_latch)
    else $error("detector latch missed a falling edge");

  fail_cause_a: assert property (
    fail_ev |-> samp_fall && lf_cnt == SAMP_FULL_M1 && !fsd_latch)
    else $error("failure without an empty sample half-period");

  fail_switch_a: assert property (
    fail_ev |=> state == ST_FAILED && fail_flag ##2 INT_CLK_EN)
    else $error("failure did not move clock and set flag");

  irq_gate_a: assert property (
    IRQ |-> fail_flag && fail_ie)
    else $error("interrupt raised without enabled flag");

  stay_failed_a: assert property (
    (state == ST_FAILED && !restart) |=> state == ST_FAILED && !PRI_CLK_EN)
    else $error("automatic return to failed clock");

  freq_hold_a: assert property (
    $changed(INT_FREQ_SEL) |-> $past(wr && PADDR == `SCFM_CTRL_OFS))
    else $error("internal_freq_select changed without a write");

  mux_excl_a: assert property (
    !(PRI_CLK_EN && INT_CLK_EN))
    else $error("both clock sources enabled");

  // monitor off means no failure in any oscillator mode
  mon_disable_a: assert property (
    (state == ST_PRIMARY && !FAIL_MON_EN) |=> state != ST_FAILED)
    else $error("failure taken with monitor disabled");

  no_early_fail_a: assert property (
    (state != ST_PRIMARY) |=> !$rose(fail_flag))
    else $error("failure flagged outside primary operation");

  // the divider must wrap at 64 low-frequency edges
  lf_wrap_a: assert property (
    (lf_rise && lf_cnt == SAMP_FULL_M1) |=> lf_cnt == 6'h00)
    else $error("sample divider did not wrap");

  wake_restart_a: assert property (
    (state == ST_PRIMARY && WAKE_EVENT && !fail_ev) |=> state == ST_OST)
    else $error("wake did not restart the start-up timer");

endmodule

// ===== hdl/scfm_map.svh
`ifndef SCFM_MAP_SVH
`define SCFM_MAP_SVH

// register byte offsets
`define SCFM_CTRL_OFS 8'h00
`define SCFM_FLAGS_OFS 8'h04
`define SCFM_CLEAR_OFS 8'h08
`define SCFM_ENABLE_OFS 8'h0C

// oscillator_control fields
`define SCFM_RESTART_BIT 0
`define SCFM_ACTIVE_BIT 3
`define SCFM_FREQ_LSB 4
`define SCFM_FREQ_MSB 6
`define SCFM_FREQ_RESET 3'h0

// interrupt_flags_2 / clear / interrupt_enables_2 layout
`define SCFM_FAIL_BIT 7

// timing counts
`define SCFM_OST_CYCLES 1024
`define SCFM_LF_DIV 64

`endif

// ===== hdl/scfm_pkg.sv
package scfm_pkg;

  typedef enum logic [2:0]
  {
    LOW_POWER_CRYSTAL,
    CRYSTAL_RESONATOR,
    HIGH_SPEED_CRYSTAL,
    EXTERNAL_CLOCK_INPUT,
    RESISTOR_CAPACITOR_OSC
  } scfm_osc_mode_t;

  typedef enum logic [2:0]
  {
    ST_POR,
    ST_POWER_UP,
    ST_OST,
    ST_PRIMARY,
    ST_FAILED
  } scfm_state_t;

endpackage

// ===== dv/scfm_osc_model.sv
module scfm_osc_model (
  input wire logic clk,
  input wire logic run,
  output logic ext_clk,
  output int falls
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  initial ext_clk = 1'b0;
  initial falls = 0;
  // period of four system cycles; a dead crystal freezes at its last level
  always @(posedge clk)
  begin
    if (!run)
    begin
      ph <= 1'b0;
      falls <= 0;
    end
    else
    begin
      ph <= !ph;
      if (ph)
      begin
        ext_clk <= !ext_clk;
        if (ext_clk)
          falls <= falls + 1;
      end
    end
  end
endmodule

// ===== dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import scfm_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, two_sp = 0, fme = 0;
  logic pup_en = 0, pup_exp = 0, wake = 0, lf = 0, run = 0, en, crys, ext;
  logic pready, pslverr, err, pri, intc, hold, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0] fsel, f;
  logic [1:0] lfc = 2'h0;
  scfm_osc_mode_t mode = LOW_POWER_CRYSTAL;
  int falls, k;
  int n_fail = 0;
  int check_count = 0;

  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    lfc <= lfc + 2'h1;
    lf <= lfc[1];
  end

  scfm_top i_dut (.CLK(clk), .SRST(srst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TWO_SPEED_EN(two_sp), .FAIL_MON_EN(fme), .OSC_MODE(mode), .POWER_UP_TIMER_EN(pup_en),
    .POWER_UP_TIMER_DONE(pup_exp), .WAKE_EVENT(wake), .EXT_CLK(ext), .LF_OSC(lf), .PRI_CLK_EN(pri),
    .INT_CLK_EN(intc), .INT_FREQ_SEL(fsel), .CPU_HOLD(hold), .IRQ(irq));
  scfm_osc_model i_osc (.clk(clk), .run(run), .ext_clk(ext), .falls(falls));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // waits for a clock grant; k gives the cycles it took
  task automatic wait_en(input logic sel, input int lim);
    k = 0;
    while (((sel ? intc : pri) !== 1'b1) && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    chk("grant_wait", 1, k < lim);
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h7a62cb09));
    for (int i = 0; i < 6; i++)
    begin
      mode <= scfm_osc_mode_t'(i % 5);
      crys = (i % 5) < 3;
      two_sp <= 1'($urandom);
      fme <= i < 5;
      pup_en <= 1'($urandom);
      pup_exp <= 0;
      run <= 0;
      srst <= 1;
      repeat (10) @(posedge clk);
      srst <= 0;
      if (i == 0)
      begin
        apb(0, 8'h00, 0);
        chk("ctrl_rst", 0, rd);
        apb(0, 8'h04, 0);
        chk("flags_rst", 0, rd);
        apb(0, 8'h10, 0);
        chk("unmapped", 1, err);
      end
      repeat (20) @(posedge clk);
      chk("int_in_ost", crys && two_sp && !pup_en, intc);
      chk("pri_early", !crys && !pup_en, pri);
      chk("hold_ost", !(crys && two_sp && !pup_en) && !(!crys && !pup_en), hold);
      pup_exp <= 1;
      run <= 1;
      wait_en(0, 8000);
      chk("ost_falls", 1, crys ? (falls >= 1024 && falls <= 1028) : falls < 8);
      apb(0, 8'h00, 0);
      chk("active", 32'h0000_0008, rd & 32'h0000_0078);
      if (crys)
      begin
        run <= 0;
        wake <= 1;
        @(posedge clk);
        wake <= 0;
        run <= 1;
        repeat (6) @(posedge clk);
        chk("wake_int", two_sp, intc);
        wait_en(0, 8000);
      end
      f = 3'($urandom);
      en = 1'($urandom);
      apb(1, 8'h00, {25'h0, f, 4'h0});
      apb(1, 8'h0C, {24'h0, en, 7'h0});
      run <= 0;
      if (fme)
      begin
        wait_en(1, 8000);
        chk("fail_delay", 1, k >= 100 && k <= 440);
        apb(0, 8'h04, 0);
        chk("fail_flag", 32'h0000_0080, rd);
        chk("irq", en, irq);
        chk("freq", f, fsel);
        chk("pri_off", 0, pri);
        run <= 1;
        repeat (300) @(posedge clk);
        chk("no_return", 0, pri);
        apb(1, 8'h0C, {24'h0, !en, 7'h0});
        // the enable lands at the access edge; look one edge later
        @(posedge clk);
        chk("irq_mask", !en, irq);
        apb(1, 8'h08, 32'h0000_0080);
        apb(0, 8'h04, 0);
        chk("flag_clr", 0, rd);
        chk("irq_clr", 0, irq);
        apb(1, 8'h00, {25'h0, f, 4'h1});
        wait_en(0, 8000);
      end
      else
      begin
        repeat (700) @(posedge clk);
        chk("no_mon", 1, pri);
        apb(0, 8'h04, 0);
        chk("no_flag", 0, rd);
      end
    end
    report_and_stop();
  end
endmodule
